// *** src/vim_top.sv ***
// Virtual input/output mapper with AHB-Lite register slave
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
module vim_top #(
  parameter int unsigned N_DI        = vim_pkg::N_DI_FULL,
  parameter int unsigned N_DO        = vim_pkg::N_DO_TERM,
  parameter int unsigned QUAL_CYCLES = vim_pkg::QUAL_CYCLES
) (
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic      [31:0]                          hrdata,
  output logic                                      hreadyout,
  output logic                                      hresp,
  input  wire logic [N_DI-1:0]                      hardware_input_terminal,
  input  wire logic [(1<<vim_pkg::FUNC_W)-1:0]      status_signal,
  output logic      [(1<<vim_pkg::FUNC_W)-1:0]      input_function_active,
  output logic      [N_DO-1:0]                      output_terminal,
  output logic                                      input_conflict_warn,
  output logic                                      output_conflict_warn,
  output logic                                      irq
);

  localparam int unsigned FW     = vim_pkg::FUNC_W;
  localparam int unsigned NF     = 1 << FW;
  localparam int unsigned NC     = vim_pkg::N_COMM_OUT;
  localparam int unsigned NE     = vim_pkg::N_EVENTS;

  typedef struct packed {
    logic [N_DI-1:0]          vin;
    logic [N_DI-1:0]          vsel;
    logic [N_DI-1:0]          pol;
    logic [NC-1:0]            comm;
    logic [N_DI-1:0][FW-1:0]  di_func;
    logic [N_DO-1:0][FW-1:0]  do_func;
    logic [NE-1:0]            irq_status;
    logic [NE-1:0]            irq_mask;
    logic [NE-1:0]            warn_prev;
    logic [NF-1:0]            func_active;
    logic [N_DO-1:0]          do_level;
    logic                     dp_valid;
    logic                     dp_write;
    logic [7:0]               dp_addr;
    logic [31:0]              rdata;
  } vim_state_t;

  vim_state_t      st;
  vim_state_t      next_st;
  logic [N_DI-1:0] hw_level;
  logic [N_DI-1:0] chan_active;
  logic            in_dup;
  logic            out_dup;
  logic [NE-1:0]   warn;

  // Every terminal is a plain general-purpose input with its own qualifier
  for (genvar g = 0; g < int'(N_DI); g++) begin : g_in
    vim_in_qual #(
      .CNT_W       (vim_pkg::QUAL_CNT_W),
      .QUAL_CYCLES (QUAL_CYCLES)
    ) u_qual (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .pin_async (hardware_input_terminal[g]),
      .level     (hw_level[g])
    );
  end

  vim_dup_check #(
    .N       (N_DI),
    .FUNC_W  (FW),
    .EXCLUDE (vim_pkg::FUNC_NONE)
  ) u_in_dup (
    .hclk    (hclk),
    .hresetn (hresetn),
    .funcs   (st.di_func),
    .dup     (in_dup)
  );

  vim_dup_check #(
    .N       (N_DO),
    .FUNC_W  (FW),
    .EXCLUDE (vim_pkg::FUNC_DO_FREE)
  ) u_out_dup (
    .hclk    (hclk),
    .hresetn (hresetn),
    .funcs   (st.do_func),
    .dup     (out_dup)
  );

  always_comb begin
    warn                          = '0;
    warn[vim_pkg::BIT_IN_DUP]     = in_dup;
    warn[vim_pkg::BIT_OUT_DUP]    = out_dup;
  end

  // Virtual values bypass the qualifier so a write acts on the next edge
  always_comb begin
    for (int i = 0; i < int'(N_DI); i++) begin
      if (st.vsel[i] == vim_pkg::VSEL_VIRTUAL) begin
        chan_active[i] = st.vin[i] ^ (st.pol[i] == vim_pkg::POL_ACTIVE_LOW);
      end else begin
        chan_active[i] = hw_level[i] ^ (st.pol[i] == vim_pkg::POL_ACTIVE_LOW);
      end
    end
  end

  always_comb begin
    logic [7:0]    a;
    logic [7:0]    ra;
    logic [7:0]    idx;
    logic [NE-1:0] clr;
    logic [NE-1:0] evt;
    logic [FW-1:0] f;
    a       = st.dp_addr;
    ra      = haddr[7:0];
    idx     = 8'h00;
    clr     = '0;
    evt     = '0;
    f       = '0;
    next_st = st;

    // Address phase: capture and prepare read data from registers
    next_st.dp_valid = 1'b0;
    if (hsel && htrans[vim_pkg::HTRANS_ACTIVE_BIT] && hready) begin
      next_st.dp_valid = 1'b1;
      next_st.dp_write = hwrite;
      next_st.dp_addr  = ra;
      if (!hwrite) begin
        // Writes leave the last read data standing on hrdata
        next_st.rdata = 32'h0000_0000;
        if (ra >= vim_pkg::OFS_VIN_BASE && ra < vim_pkg::OFS_VIN_BASE + 8'(4 * N_DI)) begin
          idx = 8'((ra - vim_pkg::OFS_VIN_BASE) >> 2);
          next_st.rdata[0] = st.vin[idx[2:0]];
        end else if (ra >= vim_pkg::OFS_COMM_BASE
                     && ra < vim_pkg::OFS_COMM_BASE + 8'(4 * NC)) begin
          idx = 8'((ra - vim_pkg::OFS_COMM_BASE) >> 2);
          next_st.rdata[0] = st.comm[idx[1:0]];
        end else if (ra >= vim_pkg::OFS_DI_FUNC_BASE
                     && ra < vim_pkg::OFS_DI_FUNC_BASE + 8'(4 * N_DI)) begin
          idx = 8'((ra - vim_pkg::OFS_DI_FUNC_BASE) >> 2);
          next_st.rdata[FW-1:0] = st.di_func[idx[2:0]];
        end else if (ra >= vim_pkg::OFS_DO_FUNC_BASE
                     && ra < vim_pkg::OFS_DO_FUNC_BASE + 8'(4 * N_DO)) begin
          idx = 8'((ra - vim_pkg::OFS_DO_FUNC_BASE) >> 2);
          next_st.rdata[FW-1:0] = st.do_func[idx[2:0]];
        end else begin
          unique case (ra)
            vim_pkg::OFS_VSEL:       next_st.rdata[N_DI-1:0] = st.vsel;
            vim_pkg::OFS_POL:        next_st.rdata[N_DI-1:0] = st.pol;
            vim_pkg::OFS_DI_STATE:   next_st.rdata[N_DI-1:0] = chan_active;
            vim_pkg::OFS_IRQ_STATUS: next_st.rdata[NE-1:0]   = st.irq_status;
            vim_pkg::OFS_IRQ_MASK:   next_st.rdata[NE-1:0]   = st.irq_mask;
            vim_pkg::OFS_WARN:       next_st.rdata[NE-1:0]   = warn;
            default:                 next_st.rdata           = 32'h0000_0000;
          endcase
        end
      end
    end

    // Data phase: writes land at the end of it
    if (st.dp_valid && st.dp_write) begin
      if (a >= vim_pkg::OFS_VIN_BASE && a < vim_pkg::OFS_VIN_BASE + 8'(4 * N_DI)) begin
        idx = 8'((a - vim_pkg::OFS_VIN_BASE) >> 2);
        next_st.vin[idx[2:0]] = hwdata[0];
      end else if (a >= vim_pkg::OFS_COMM_BASE && a < vim_pkg::OFS_COMM_BASE + 8'(4 * NC)) begin
        idx = 8'((a - vim_pkg::OFS_COMM_BASE) >> 2);
        next_st.comm[idx[1:0]] = hwdata[0];
      end else if (a >= vim_pkg::OFS_DI_FUNC_BASE
                   && a < vim_pkg::OFS_DI_FUNC_BASE + 8'(4 * N_DI)) begin
        idx = 8'((a - vim_pkg::OFS_DI_FUNC_BASE) >> 2);
        next_st.di_func[idx[2:0]] = hwdata[FW-1:0];
      end else if (a >= vim_pkg::OFS_DO_FUNC_BASE
                   && a < vim_pkg::OFS_DO_FUNC_BASE + 8'(4 * N_DO)) begin
        idx = 8'((a - vim_pkg::OFS_DO_FUNC_BASE) >> 2);
        next_st.do_func[idx[2:0]] = hwdata[FW-1:0];
      end else begin
        unique case (a)
          vim_pkg::OFS_VSEL:       next_st.vsel     = hwdata[N_DI-1:0];
          vim_pkg::OFS_POL:        next_st.pol      = hwdata[N_DI-1:0];
          vim_pkg::OFS_IRQ_STATUS: clr              = hwdata[NE-1:0];
          vim_pkg::OFS_IRQ_MASK:   next_st.irq_mask = hwdata[NE-1:0];
          default:                 next_st.vsel     = st.vsel;
        endcase
      end
    end

    // A warning that newly appears is an event; set beats a same-cycle clear
    next_st.warn_prev  = warn;
    evt                = warn & ~st.warn_prev;
    next_st.irq_status = (st.irq_status & ~clr) | evt;

    // Input functions: each function follows the channels assigned to it
    next_st.func_active = '0;
    for (int i = 0; i < int'(N_DI); i++) begin
      if (st.di_func[i] != FW'(vim_pkg::FUNC_NONE) && chan_active[i]) begin
        next_st.func_active[st.di_func[i]] = 1'b1;
      end
    end

    // Output terminals: communication functions or the internal status signal
    for (int j = 0; j < int'(N_DO); j++) begin
      f = st.do_func[j];
      if (f >= FW'(vim_pkg::FUNC_COMM_FIRST) && f <= FW'(vim_pkg::FUNC_COMM_LAST)) begin
        next_st.do_level[j] = st.comm[2'(f - FW'(vim_pkg::FUNC_COMM_FIRST))];
      end else begin
        next_st.do_level[j] = status_signal[f];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;
      st.vin      <= {N_DI{vim_pkg::RST_VIN}};
      st.vsel     <= {N_DI{vim_pkg::RST_VSEL}};
      st.pol      <= {N_DI{vim_pkg::RST_POL}};
      st.comm     <= {NC{vim_pkg::RST_COMM}};
      st.irq_mask <= {NE{vim_pkg::RST_MASK}};
      st.di_func  <= {N_DI{FW'(vim_pkg::RST_FUNC)}};
      st.do_func  <= {N_DO{FW'(vim_pkg::RST_FUNC)}};
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave; hsize is not checked since only word transfers occur
  assign hrdata                = st.rdata;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign input_function_active = st.func_active;
  assign output_terminal       = st.do_level;
  assign input_conflict_warn   = in_dup;
  assign output_conflict_warn  = out_dup;
  assign irq                   = |(st.irq_status & st.irq_mask);

endmodule

// *** src/vim_pkg.sv ***
// Shared constants of the virtual input/output mapper
package vim_pkg;

  // Channel counts and function number width
  localparam int unsigned N_DI_FULL    = 8;
  localparam int unsigned N_COMM_OUT   = 4;
  localparam int unsigned N_DO_TERM    = 4;
  localparam int unsigned FUNC_W       = 8;

  // Input qualification time and its cycle count at the bus clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned QUAL_TIME_MS  = 3;
  localparam int unsigned QUAL_CYCLES   =
    (QUAL_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned QUAL_CNT_W    = 20;

  // Register byte offsets
  localparam logic [7:0] OFS_VIN_BASE     = 8'h00;
  localparam logic [7:0] OFS_COMM_BASE    = 8'h20;
  localparam logic [7:0] OFS_VSEL         = 8'h40;
  localparam logic [7:0] OFS_POL          = 8'h44;
  localparam logic [7:0] OFS_DI_STATE     = 8'h48;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h4C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h50;
  localparam logic [7:0] OFS_WARN         = 8'h54;
  localparam logic [7:0] OFS_DI_FUNC_BASE = 8'h60;
  localparam logic [7:0] OFS_DO_FUNC_BASE = 8'h80;

  // Status, mask and warning bit positions
  localparam int unsigned BIT_IN_DUP  = 0;
  localparam int unsigned BIT_OUT_DUP = 1;
  localparam int unsigned N_EVENTS    = 2;

  // Function numbers and setting codes
  localparam logic [7:0] FUNC_NONE       = 8'h00;
  localparam logic [7:0] FUNC_DO_FREE    = 8'h80;
  localparam logic [7:0] FUNC_COMM_FIRST = 8'h91;
  localparam logic [7:0] FUNC_COMM_LAST  = 8'h94;
  localparam logic       VSEL_VIRTUAL    = 1'b1;
  localparam logic       POL_ACTIVE_LOW  = 1'b1;

  // Reset values
  localparam logic       RST_VIN   = 1'b0;
  localparam logic       RST_COMM  = 1'b0;
  localparam logic       RST_VSEL  = 1'b0;
  localparam logic       RST_POL   = 1'b0;
  localparam logic       RST_MASK  = 1'b0;
  localparam logic [7:0] RST_FUNC  = 8'h00;

  // AHB transfer type bit that marks an active transfer
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

endpackage

// *** src/vim_in_qual.sv ***
// One hardware input terminal: synchroniser and persistence qualifier
`timescale 1ns/1ns
module vim_in_qual #(
  parameter int unsigned CNT_W       = vim_pkg::QUAL_CNT_W,
  parameter int unsigned QUAL_CYCLES = vim_pkg::QUAL_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_async,
  output logic      level
);

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic             level;
    logic [CNT_W-1:0] cnt;
  } vim_qual_state_t;

  vim_qual_state_t st;
  vim_qual_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = pin_async;
    next_st.sync2 = st.sync1;
    if (st.sync2 == st.level) begin
      next_st.cnt = '0;
    end else if (st.cnt == CNT_W'(QUAL_CYCLES)) begin
      // Held past the full window, so strictly longer than it
      next_st.level = st.sync2;
      next_st.cnt   = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// *** src/vim_dup_check.sv ***
// Duplicate function assignment detector over a set of terminals
`timescale 1ns/1ns
module vim_dup_check #(
  parameter int unsigned N       = 4,
  parameter int unsigned FUNC_W  = vim_pkg::FUNC_W,
  parameter logic [7:0]  EXCLUDE = vim_pkg::FUNC_NONE
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic [N-1:0][FUNC_W-1:0]    funcs,
  output logic                             dup
);

  typedef struct packed {
    logic dup;
  } vim_dup_state_t;

  vim_dup_state_t st;
  vim_dup_state_t next_st;

  // Registered compare of current settings: warning follows every change one cycle later
  always_comb begin
    next_st.dup = 1'b0;
    for (int i = 0; i < int'(N); i++) begin
      for (int j = i + 1; j < int'(N); j++) begin
        if (funcs[i] == funcs[j] && funcs[i] != FUNC_W'(EXCLUDE)) begin
          next_st.dup = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dup = st.dup;

endmodule

// *** testbench/vim_pins_model.sv ***
// Bouncing switches on the hardware input terminals
`timescale 1ns/1ns
module vim_pins_model #(
  parameter int unsigned N      = 8,
  parameter int unsigned BOUNCE = 3
) (
  input  wire logic         hclk,
  input  wire logic [N-1:0] sw,
  output logic      [N-1:0] pins
);
  logic [N-1:0] last;
  int           cnt;
  initial begin
    pins = '0;
    last = '0;
    cnt  = 0;
  end
  // Every terminal chatters after any switch moves, shorter than qualification
  always @(posedge hclk) begin
    if (sw !== last) begin
      last <= sw;
      cnt  <= BOUNCE;
    end else if (cnt > 0) begin
      pins <= ~pins;
      cnt  <= cnt - 1;
    end else begin
      pins <= last;
    end
  end
endmodule

// *** testbench/vim_checker.sv ***
// Concurrent checks on the mapper's ports
`timescale 1ns/1ns
module vim_checker #(
  parameter int unsigned N_DI        = 8,
  parameter int unsigned N_DO        = 4,
  parameter int unsigned QUAL_CYCLES = 8
) (
  input wire logic                            hclk,
  input wire logic                            hresetn,
  input wire logic                            hsel,
  input wire logic [31:0]                     haddr,
  input wire logic [1:0]                      htrans,
  input wire logic                            hwrite,
  input wire logic [2:0]                      hsize,
  input wire logic [31:0]                     hwdata,
  input wire logic                            hready,
  input wire logic [31:0]                     hrdata,
  input wire logic                            hreadyout,
  input wire logic                            hresp,
  input wire logic [N_DI-1:0]                 hardware_input_terminal,
  input wire logic [(1<<vim_pkg::FUNC_W)-1:0] status_signal,
  input wire logic [(1<<vim_pkg::FUNC_W)-1:0] input_function_active,
  input wire logic [N_DO-1:0]                 output_terminal,
  input wire logic                            input_conflict_warn,
  input wire logic                            output_conflict_warn,
  input wire logic                            irq
);
  logic            pend_wr;
  logic [7:0]      pend_a;
  logic [N_DI-1:0] vin, vsel, pol;
  logic [3:0]      comm;
  logic [1:0]      mask;
  logic [7:0]      in_func [N_DI];
  logic [7:0]      out_func [N_DO];
  logic            ever_warn, in_dup, out_dup;
  logic [255:0]    exp_ifa;
  logic [N_DO-1:0] exp_term;
  // Shadow of the writable registers, rebuilt from bus traffic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_wr <= 1'b0;
      pend_a <= 8'h00;
      vin <= '0;
      vsel <= '0;
      pol <= '0;
      comm <= '0;
      mask <= '0;
      in_func <= '{default: 8'h00};
      out_func <= '{default: 8'h00};
      ever_warn <= 1'b0;
    end else begin
      pend_wr <= hsel && htrans[1] && hready && hwrite;
      pend_a <= haddr[7:0];
      ever_warn <= ever_warn || input_conflict_warn || output_conflict_warn;
      if (pend_wr) begin
        for (int i = 0; i < N_DI; i++) begin
          if (pend_a == vim_pkg::OFS_VIN_BASE + 8'(4 * i)) vin[i] <= hwdata[0];
          if (pend_a == vim_pkg::OFS_DI_FUNC_BASE + 8'(4 * i)) in_func[i] <= hwdata[7:0];
        end
        for (int j = 0; j < N_DO; j++) begin
          if (pend_a == vim_pkg::OFS_COMM_BASE + 8'(4 * j)) comm[j] <= hwdata[0];
          if (pend_a == vim_pkg::OFS_DO_FUNC_BASE + 8'(4 * j)) out_func[j] <= hwdata[7:0];
        end
        if (pend_a == vim_pkg::OFS_VSEL) vsel <= hwdata[N_DI-1:0];
        if (pend_a == vim_pkg::OFS_POL) pol <= hwdata[N_DI-1:0];
        if (pend_a == vim_pkg::OFS_IRQ_MASK) mask <= hwdata[1:0];
      end
    end
  end
  always_comb begin
    in_dup = 1'b0;
    out_dup = 1'b0;
    exp_ifa = '0;
    exp_term = '0;
    for (int i = 0; i < N_DI; i++) begin
      if (in_func[i] != 8'h00) exp_ifa[in_func[i]] = exp_ifa[in_func[i]] | (vin[i] ^ pol[i]);
      for (int k = i + 1; k < N_DI; k++)
        if (in_func[i] == in_func[k] && in_func[i] != 8'h00) in_dup = 1'b1;
    end
    for (int j = 0; j < N_DO; j++) begin
      exp_term[j] = status_signal[out_func[j]];
      if (out_func[j] >= vim_pkg::FUNC_COMM_FIRST && out_func[j] <= vim_pkg::FUNC_COMM_LAST)
        exp_term[j] = comm[out_func[j][1:0] - 2'd1];
      for (int k = j + 1; k < N_DO; k++)
        if (out_func[j] == out_func[k] && out_func[j] != vim_pkg::FUNC_DO_FREE) out_dup = 1'b1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_in_rise;
    $rose(input_conflict_warn) && mask[0];
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("Bus slave stalled or answered with an error");
  a_read_hold: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite))
    else $error("Read data moved without a read");
  a_irq_raise: assert property (s_in_rise |=> irq)
    else $error("Interrupt missing after an input conflict");
  a_irq_quiet: assert property (!ever_warn |-> !irq)
    else $error("Interrupt without any conflict");
  a_in_warn: assert property ($past(hresetn) |-> input_conflict_warn == $past(in_dup))
    else $error("Input conflict warning wrong");
  a_out_warn: assert property ($past(hresetn) |-> output_conflict_warn == $past(out_dup))
    else $error("Output conflict warning wrong");
  a_term_map: assert property ($past(hresetn) |-> output_terminal == $past(exp_term))
    else $error("Output terminal source wrong");
  a_vin_map: assert property (&vsel |=> input_function_active == $past(exp_ifa))
    else $error("Virtual input level not applied");
  a_func0_idle: assert property (!input_function_active[0])
    else $error("Function zero reported active");
  c_read: cover property (s_read_taken);
endmodule

bind vim_top vim_checker #(.N_DI(N_DI), .N_DO(N_DO), .QUAL_CYCLES(QUAL_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .hardware_input_terminal(hardware_input_terminal),
  .status_signal(status_signal), .input_function_active(input_function_active),
  .output_terminal(output_terminal), .input_conflict_warn(input_conflict_warn),
  .output_conflict_warn(output_conflict_warn), .irq(irq));

// *** testbench/vim_tb_top.sv ***
// Self-checking testbench of the mapper
`timescale 1ns/1ns
module vim_tb_top;
  localparam int unsigned QC = 8;
  logic         hclk = 1'b0;
  logic         hresetn, hsel, hwrite, hready, hreadyout, hresp, in_warn, out_warn, irq;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, r, d;
  logic [7:0]   pins, sw;
  logic [255:0] status_signal, ifa;
  logic [3:0]   out_term;
  logic [7:0]   f [4];
  int           seed, err_count, n_tests, cyc, i, j;
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  vim_top #(.N_DI(8), .N_DO(4), .QUAL_CYCLES(QC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hardware_input_terminal(pins),
    .status_signal(status_signal), .input_function_active(ifa), .output_terminal(out_term),
    .input_conflict_warn(in_warn), .output_conflict_warn(out_warn), .irq(irq));
  vim_pins_model #(.N(8), .BOUNCE(3)) u_sw (.hclk(hclk), .sw(sw), .pins(pins));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic note(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    note(g, e);
  endtask
  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    note(g, e);
  endtask
  // Caller stands just after a rising edge; returns at the edge that takes the data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [7:0] ad(input logic [7:0] b, input int k);
    return b + 8'(4 * k);
  endfunction
  function automatic logic exp_term(input logic [7:0] fn, input logic [3:0] c);
    if (fn >= vim_pkg::FUNC_COMM_FIRST && fn <= vim_pkg::FUNC_COMM_LAST)
      return c[fn - vim_pkg::FUNC_COMM_FIRST];
    return status_signal[fn];
  endfunction
  task automatic set_out;
    for (int k = 0; k < 4; k++) wr(ad(vim_pkg::OFS_DO_FUNC_BASE, k), {24'h000000, f[k]});
    wt(3);
  endtask
  task automatic term_check(input logic [3:0] c);
    logic [3:0] e;
    for (int k = 0; k < 4; k++) e[k] = exp_term(f[k], c);
    chk_pin({28'h0000000, out_term}, {28'h0000000, e});
  endtask
  // Hang guard, well above the roughly 530 cycles the sequence needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    seed = 46777;
    {hsel, hwrite, htrans, haddr, hwdata, sw, status_signal} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    wt(16);
    hresetn <= 1'b1;
    wt(1);
    for (i = 0; i < 8; i++) begin
      rd(ad(vim_pkg::OFS_VIN_BASE, i));
      chk_reg(d, 32'h0);
      rd(ad(vim_pkg::OFS_DI_FUNC_BASE, i));
      chk_reg(d, 32'h0);
      if (i < 4) begin
        rd(ad(vim_pkg::OFS_COMM_BASE, i));
        chk_reg(d, 32'h0);
      end
    end
    wr(8'h5C, 32'hFFFFFFFF);
    rd(8'h5C);
    chk_reg(d, 32'h0);
    rd(vim_pkg::OFS_IRQ_STATUS);
    chk_reg(d, 32'h2);
    wr(vim_pkg::OFS_IRQ_STATUS, 32'h3);
    // Communication outputs, functions given in terminal order
    for (j = 0; j < 4; j++) f[j] = vim_pkg::FUNC_COMM_FIRST + 8'(j);
    set_out();
    repeat (4) begin
      r = $random(seed);
      for (j = 0; j < 4; j++) wr(ad(vim_pkg::OFS_COMM_BASE, j), {31'h0, r[j]});
      wt(2);
      term_check(r[3:0]);
    end
    chk_pin({31'h0, out_warn}, 32'h0);
    for (j = 0; j < 4; j++) f[j] = 8'(40 * j + 5);
    set_out();
    repeat (4) begin
      status_signal <= {8{$random(seed)}};
      wt(2);
      term_check(r[3:0]);
    end
    f[0] = vim_pkg::FUNC_DO_FREE;
    f[1] = vim_pkg::FUNC_DO_FREE;
    set_out();
    chk_pin({31'h0, out_warn}, 32'h0);
    f[0] = 8'h92;
    f[1] = 8'h92;
    set_out();
    chk_pin({31'h0, out_warn}, 32'h1);
    term_check(r[3:0]);
    f[0] = 8'h91;
    set_out();
    chk_pin({31'h0, out_warn}, 32'h0);
    wr(vim_pkg::OFS_IRQ_STATUS, 32'h3);
    // Every channel taken from its virtual value
    wr(vim_pkg::OFS_VSEL, 32'hFF);
    for (i = 0; i < 8; i++) wr(ad(vim_pkg::OFS_DI_FUNC_BASE, i), 32'(i + 1));
    repeat (8) begin
      r = $random(seed);
      wr(vim_pkg::OFS_POL, {24'h0, r[15:8]});
      for (i = 0; i < 8; i++) wr(ad(vim_pkg::OFS_VIN_BASE, i), {31'h0, r[i]});
      wt(2);
      chk_pin({23'h0, ifa[8:0]}, {23'h0, r[7:0] ^ r[15:8], 1'b0});
      rd(vim_pkg::OFS_DI_STATE);
      chk_reg(d, {24'h0, r[7:0] ^ r[15:8]});
    end
    // Two channels share a function; interrupt masked and cleared
    wr(vim_pkg::OFS_IRQ_MASK, 32'h3);
    wr(ad(vim_pkg::OFS_DI_FUNC_BASE, 5), 32'h3);
    wt(3);
    rd(vim_pkg::OFS_WARN);
    chk_reg(d, 32'h1);
    chk_pin({31'h0, irq}, 32'h1);
    wr(vim_pkg::OFS_IRQ_MASK, 32'h2);
    wt(1);
    chk_pin({31'h0, irq}, 32'h0);
    wr(vim_pkg::OFS_IRQ_MASK, 32'h1);
    wr(ad(vim_pkg::OFS_DI_FUNC_BASE, 5), 32'h0);
    wr(ad(vim_pkg::OFS_DI_FUNC_BASE, 6), 32'h0);
    wt(3);
    rd(vim_pkg::OFS_WARN);
    chk_reg(d, 32'h0);
    chk_pin({31'h0, irq}, 32'h1);
    wr(vim_pkg::OFS_IRQ_STATUS, 32'h1);
    wt(1);
    chk_pin({31'h0, irq}, 32'h0);
    // Hardware terminal through the qualifier, then active low
    wr(vim_pkg::OFS_VSEL, 32'h0);
    wr(vim_pkg::OFS_POL, 32'h0);
    wt(30);
    chk_pin({24'h0, ifa[8:1]}, 32'h0);
    sw <= 8'h01;
    wt(QC);
    chk_pin({24'h0, ifa[8:1]}, 32'h0);
    wt(30);
    chk_pin({24'h0, ifa[8:1]}, 32'h1);
    wr(vim_pkg::OFS_POL, 32'h1);
    wt(30);
    chk_pin({24'h0, ifa[8:1]}, 32'h0);
    sw <= 8'h00;
    wt(40);
    chk_pin({24'h0, ifa[8:1]}, 32'h1);
    close_out();
  end
endmodule
